// >>> hdl/srb_fifo.sv
// Purpose: small staging FIFO between converter and circular buffer.
// Assumes: one clock; in_ready and out_valid are combinational from count.
// Notes:   drain side may stall, so the converter sees honest back-pressure.
module srb_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // flush
  input  wire logic             flush
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_reg;
  logic [PW-1:0]    rp_reg;
  logic [PW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == PW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == PW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// >>> hdl/srb_pkg.sv
// Purpose: constants and types shared by the result circular buffer.
// Assumes: one clock, clk_sys at 40 MHz; asynchronous active-low reset.
// Notes:   buffer locations are numbered 1..64; storage indices are 0..63.
// Overview of operation
// RULE1: results of all kinds land in a 64-entry circular buffer.
// RULE2: buffering runs only while buffer-config bit D7 is one.
// RULE3: read, write and trigger indices steer reading, writing and interrupt.
// RULE4: trigger level counts single values, not coordinate pairs.
// RULE5: buffer reset puts read and write at 1, trigger at level.
// RULE6: writes reaching the trigger raise data-available on the chosen pin.
// RULE7: while buffering, touch needs self control, auxiliary needs host control.
// RULE8: single-shot stops at trigger; first read clears, restarts, moves trigger.
// RULE9: continuous restarts at once and moves trigger by the level.
// RULE10: continuous interrupt drops on next write or first read.
// RULE11: reading an empty buffer leaves the read index alone.
// RULE12: writing a full buffer overwrites and pushes read index one on.
// RULE13: full and empty status sit at buffer-config bits D1-D0.
// RULE14: update-control D7 picks SPI (0) or I2C (1) for buffer reads.
// RULE15: update-control D6 picks automatic collision halt (0) or software hold.
// RULE16: with software hold, D5 one freezes updates, zero lets them run.
// RULE17: read word D15 is the full flag; D13 is reserved.
// RULE18: read word D14 is the empty flag, set reading the last value.
// RULE19: read word D12 tags the value kind.
// RULE20: multi-input results arrive and are stored in the fixed scan order.
// RULE21: result nibble fills D11-D8, result byte fills D7-D0.
// RULE22: host chooses the scanned inputs through the scan-select field.
// RULE23: indices wrap from 64 to 1; trigger advances modulo depth.
package srb_pkg;

  localparam int unsigned DEPTH       = 64;
  localparam int unsigned IDX_W       = 6;
  localparam int unsigned LVL_W       = 7;
  localparam int unsigned ENT_W       = 13;
  localparam int unsigned STAGE_DEPTH = 16;

  // buffer configuration register fields
  localparam int unsigned BCFG_EN_BIT    = 7;
  localparam int unsigned BCFG_EMPTY_BIT = 0;
  localparam int unsigned BCFG_FULL_BIT  = 1;

  // buffer update control register fields
  localparam int unsigned UPD_PORT_BIT = 7;
  localparam int unsigned UPD_MODE_BIT = 6;
  localparam int unsigned UPD_HOLD_BIT = 5;
  localparam logic [7:0]  UPD_RESET    = 8'h00;

  // read word fields
  localparam int unsigned RW_FULL_BIT  = 15;
  localparam int unsigned RW_EMPTY_BIT = 14;
  localparam int unsigned RW_TAG_BIT   = 12;

  // reset values of indices (location 1 is index 0)
  localparam logic [IDX_W-1:0] IDX_RESET  = 6'h00;
  localparam logic [LVL_W-1:0] CNT_FULL   = 7'h40;
  localparam logic [LVL_W-1:0] LVL_RESET  = 7'h01;

  typedef enum logic [1:0] {SRB_IDLE, SRB_RUN, SRB_WAIT} srb_state_t;

endpackage

// >>> hdl/srb_result_buffer.sv
// Purpose: 64-entry circular result buffer with trigger interrupt.
// Assumes: converter and host logic share clk_sys; no synchronisers needed.
// Notes:   registers appear as plain write strobes and read-back ports.
module srb_result_buffer
  import srb_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  // buffer configuration register
  input  wire logic                       bcfg_wr,
  input  wire logic [7:0]                 bcfg_wdata,
  output logic      [7:0]                 bcfg_rdata,
  // buffer update control register
  input  wire logic                       upd_wr,
  input  wire logic [7:0]                 upd_wdata,
  output logic      [7:0]                 upd_rdata,
  // static settings
  input  wire logic [srb_pkg::LVL_W-1:0]  trigger_level,
  input  wire logic                       continuous_mode,
  input  wire logic                       self_ctrl_mode,
  input  wire logic                       int_pin_sel,
  // converter results
  input  wire logic                       res_valid,
  output logic                            res_ready,
  input  wire logic [3:0]                 result_high_nibble,
  input  wire logic [7:0]                 result_low_byte,
  input  wire logic                       value_tag,
  // conversion control
  output logic                            touch_conv_allow,
  output logic                            aux_conv_allow,
  output logic                            conv_set_start,
  // host reads
  input  wire logic                       rd_req_spi,
  input  wire logic                       rd_req_i2c,
  output logic      [15:0]                buffer_read_word,
  output logic                            rd_valid,
  // data-available pins
  output logic                            general_pin_one,
  output logic                            general_pin_two,
  // indices, locations 1..64
  output logic      [srb_pkg::LVL_W-1:0]  read_index,
  output logic      [srb_pkg::LVL_W-1:0]  write_index,
  output logic      [srb_pkg::LVL_W-1:0]  trigger_index
);
  import srb_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [LVL_W-1:0] loc_of(input logic [IDX_W-1:0] idx);
    loc_of = {1'b0, idx} + 7'h01;
  endfunction

  // level 64 moves the trigger a whole turn, i.e. index unchanged
  function automatic logic [IDX_W-1:0] step_by(input logic [IDX_W-1:0] idx,
                                              input logic [LVL_W-1:0] lvl);
    step_by = idx + lvl[IDX_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [ENT_W-1:0] store [DEPTH];
  logic             buf_en_reg;
  logic [7:0]       upd_reg;
  logic [IDX_W-1:0] rd_idx_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [IDX_W-1:0] trg_idx_reg;
  logic [LVL_W-1:0] cnt_reg;
  logic             int_reg;
  logic             read_seen_reg;
  srb_state_t       state_reg;

  logic             buf_reset;
  logic             rd_req;
  logic             rd_take;
  logic             wr_hold;
  logic             wr_take;
  logic             full;
  logic             empty;
  logic             trig_hit;
  logic             restart;
  logic             stg_valid;
  logic [ENT_W-1:0] stg_data;

  assign buf_reset = bcfg_wr && bcfg_wdata[BCFG_EN_BIT];
  assign full      = (cnt_reg == CNT_FULL);
  assign empty     = (cnt_reg == '0);

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      buf_en_reg <= 1'b0;
    end else if (bcfg_wr) begin
      buf_en_reg <= bcfg_wdata[BCFG_EN_BIT];                       // [RULE2]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      upd_reg <= UPD_RESET;
    end else if (upd_wr) begin
      upd_reg <= {upd_wdata[7:5], 5'h00};
    end
  end

  assign upd_rdata  = upd_reg;
  assign bcfg_rdata = {buf_en_reg, 5'h00, full, empty};            // [RULE13]

  // ----------------------------------------------------------------
  // staging FIFO and write stall
  // ----------------------------------------------------------------
  srb_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   ({value_tag, result_high_nibble, result_low_byte}), // [RULE19] [RULE21]
    .out_valid (stg_valid),
    .out_ready (!wr_hold),
    .out_data  (stg_data),
    .flush     (buf_reset)
  );

  // host-side read selected by port bit; the other port is ignored
  assign rd_req = upd_reg[UPD_PORT_BIT] ? rd_req_i2c : rd_req_spi; // [RULE14]
  assign rd_take = rd_req && buf_en_reg && !empty;                 // [RULE11]

  // automatic mode stalls a write colliding with a read; software mode obeys hold
  always_comb begin
    if (upd_reg[UPD_MODE_BIT]) begin
      wr_hold = upd_reg[UPD_HOLD_BIT];                             // [RULE16]
    end else begin
      wr_hold = rd_req;                                            // [RULE15]
    end
    if (buf_en_reg && state_reg != SRB_RUN) begin
      wr_hold = 1'b1;                                              // [RULE8]
    end
  end

  // results written in arrival order, which follows the scan sequence
  assign wr_take  = stg_valid && !wr_hold && buf_en_reg && state_reg == SRB_RUN; // [RULE20]
  assign trig_hit = wr_take && (wr_idx_reg == trg_idx_reg);        // [RULE6]

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SRB_IDLE;
    end else if (bcfg_wr) begin
      state_reg <= bcfg_wdata[BCFG_EN_BIT] ? SRB_RUN : SRB_IDLE;
    end else begin
      case (state_reg)
        SRB_RUN: begin
          if (trig_hit && !continuous_mode) begin
            state_reg <= SRB_WAIT;                                 // [RULE8]
          end
        end
        SRB_WAIT: begin
          if (rd_take) begin
            state_reg <= SRB_RUN;                                  // [RULE8]
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  assign restart = (state_reg == SRB_WAIT && rd_take && !bcfg_wr)
                || (trig_hit && continuous_mode);                  // [RULE9]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_set_start <= 1'b0;
    end else begin
      conv_set_start <= restart || buf_reset;
    end
  end

  assign touch_conv_allow = !buf_en_reg || self_ctrl_mode;         // [RULE7]
  assign aux_conv_allow   = !buf_en_reg || !self_ctrl_mode;        // [RULE7]

  // ----------------------------------------------------------------
  // indices and storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wr_take) begin
      store[wr_idx_reg] <= stg_data;                               // [RULE1]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_idx_reg <= IDX_RESET;
    end else if (buf_reset) begin
      wr_idx_reg <= IDX_RESET;                                     // [RULE5]
    end else if (wr_take) begin
      wr_idx_reg <= wr_idx_reg + 6'h01;                            // [RULE3] [RULE23]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_idx_reg <= IDX_RESET;
    end else if (buf_reset) begin
      rd_idx_reg <= IDX_RESET;                                     // [RULE5]
    end else if (rd_take || (wr_take && full)) begin
      rd_idx_reg <= rd_idx_reg + 6'h01;                            // [RULE12] [RULE23]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trg_idx_reg <= IDX_RESET;
    end else if (buf_reset) begin
      trg_idx_reg <= step_by(IDX_RESET, trigger_level - 7'h01);    // [RULE5]
    end else if (restart) begin
      trg_idx_reg <= step_by(trg_idx_reg, trigger_level);          // [RULE4] [RULE23]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (buf_reset) begin
      cnt_reg <= '0;
    end else if (wr_take && !rd_take && !full) begin
      cnt_reg <= cnt_reg + 7'h01;
    end else if (rd_take && !wr_take) begin
      cnt_reg <= cnt_reg - 7'h01;
    end
  end

  assign read_index    = loc_of(rd_idx_reg);
  assign write_index   = loc_of(wr_idx_reg);
  assign trigger_index = loc_of(trg_idx_reg);

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      read_seen_reg <= 1'b0;
    end else if (trig_hit || buf_reset) begin
      read_seen_reg <= 1'b0;
    end else if (rd_take) begin
      read_seen_reg <= 1'b1;
    end
  end

  // a new trigger in the clearing cycle keeps the interrupt up
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_reg <= 1'b0;
    end else if (trig_hit) begin
      int_reg <= 1'b1;                                             // [RULE6]
    end else if (buf_reset || !buf_en_reg) begin
      int_reg <= 1'b0;
    end else if (rd_take && !read_seen_reg) begin
      int_reg <= 1'b0;                                             // [RULE8] [RULE10]
    end else if (continuous_mode && wr_take) begin
      int_reg <= 1'b0;                                             // [RULE10]
    end
  end

  // pin level low means data available
  assign general_pin_one = !(int_reg && !int_pin_sel);             // [RULE6]
  assign general_pin_two = !(int_reg && int_pin_sel);              // [RULE6]

  // ----------------------------------------------------------------
  // read word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      buffer_read_word <= 16'h4000;
      rd_valid         <= 1'b0;
    end else begin
      rd_valid <= rd_req && buf_en_reg;
      if (rd_req && buf_en_reg) begin
        buffer_read_word[RW_FULL_BIT]  <= full;                    // [RULE17]
        buffer_read_word[RW_EMPTY_BIT] <= empty || (cnt_reg == 7'h01 && !wr_take); // [RULE18]
        buffer_read_word[13]           <= 1'b0;                    // [RULE17]
        buffer_read_word[RW_TAG_BIT:0] <= empty ? buffer_read_word[RW_TAG_BIT:0]
                                                : store[rd_idx_reg]; // [RULE19] [RULE21]
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_reset_write;
    bcfg_wr && bcfg_wdata[BCFG_EN_BIT];
  endsequence

  AST_RESET_INDICES: assert property (s_reset_write |=>             // [RULE5]
    read_index == 7'h01 && write_index == 7'h01)
    else $error("indices not at location 1 after buffer reset");

  AST_EMPTY_READ: assert property (rd_req && empty && !bcfg_wr |=>   // [RULE11]
    $stable(rd_idx_reg))
    else $error("read index moved on empty read");

  AST_FULL_OVERWRITE: assert property (wr_take && full && !rd_take && !bcfg_wr |=> // [RULE12]
    rd_idx_reg == $past(rd_idx_reg) + 6'h01 && full)
    else $error("full write did not push read index");

  AST_TRIG_INT: assert property (trig_hit |=> int_reg &&            // [RULE6]
    (general_pin_one == int_pin_sel))
    else $error("trigger did not raise data available");

  AST_SINGLE_STOP: assert property (trig_hit && !continuous_mode && !bcfg_wr |=> // [RULE8]
    state_reg == SRB_WAIT && !wr_take)
    else $error("single shot kept writing after trigger");

  AST_CONT_ADVANCE: assert property (trig_hit && continuous_mode && !bcfg_wr |=> // [RULE9]
    trg_idx_reg == step_by($past(trg_idx_reg), trigger_level) ##0 conv_set_start)
    else $error("continuous trigger did not advance");

  AST_CONT_CLEAR: assert property (int_reg && continuous_mode && wr_take && !trig_hit // [RULE10]
    |=> !int_reg)
    else $error("continuous interrupt not cleared by write");

  AST_HOLD: assert property (buf_en_reg && upd_reg[UPD_MODE_BIT] && upd_reg[UPD_HOLD_BIT] // [RULE16]
    |-> !wr_take)
    else $error("write taken during software hold");

  AST_PORT_SEL: assert property (upd_reg[UPD_PORT_BIT] && rd_req_spi && !rd_req_i2c // [RULE14]
    |=> !rd_valid)
    else $error("spi read answered while i2c selected");

  AST_STATUS: assert property (bcfg_rdata[1:0] == {full, empty} && (full -> !empty)) // [RULE13]
    else $error("status bits disagree");

  sequence s_single_read;
    state_reg == SRB_WAIT && rd_take && !bcfg_wr;
  endsequence

  AST_SINGLE_RESTART: assert property (s_single_read |=> !int_reg && conv_set_start // [RULE8]
    && trg_idx_reg == step_by($past(trg_idx_reg), $past(trigger_level)))
    else $error("single shot read did not restart conversions");

  AST_READ_ANSWER: assert property (rd_req && buf_en_reg |=> rd_valid) // [RULE14]
    else $error("selected read not answered");

  AST_READ_FULL: assert property (rd_req && buf_en_reg && full |=> // [RULE17]
    buffer_read_word[RW_FULL_BIT])
    else $error("full flag missing from read word");

  AST_LAST_EMPTY: assert property (rd_take && cnt_reg == 7'h01 && !wr_take |=> // [RULE18]
    buffer_read_word[RW_EMPTY_BIT] && empty)
    else $error("empty flag missing on last read");

  AST_WRAP: assert property (wr_take && wr_idx_reg == 6'h3f && !bcfg_wr |=> // [RULE23]
    write_index == 7'h01)
    else $error("write index did not wrap to location 1");

  AST_SEQ_MODES: assert property (buf_en_reg |-> touch_conv_allow ^ aux_conv_allow) // [RULE7]
    else $error("conversion kinds not split while buffering");

  AST_DISABLED: assert property (!buf_en_reg |-> !wr_take ##1 !rd_valid) // [RULE2]
    else $error("buffer active while disabled");

endmodule

// >>> verif/srb_host_model.sv
// Purpose: host that reads buffer words over the chosen port.
// Assumes: shares clk_sys; one read in flight at a time.
// Notes:   strobe lasts one cycle; the word is kept until the next read.
module srb_host_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // bench control
  input  wire logic        start,
  input  wire logic        use_i2c,
  output logic             got,
  output logic [15:0]      word,
  // device read port
  output logic             rd_req_spi,
  output logic             rd_req_i2c,
  input  wire logic [15:0] buffer_read_word,
  input  wire logic        rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------
  // strobes
  // ------
  // the model does not know the port setting, so it can knock on the wrong one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_req_spi <= 1'b0;
      rd_req_i2c <= 1'b0;
    end else begin
      rd_req_spi <= start & ~use_i2c;
      rd_req_i2c <= start & use_i2c;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      got  <= 1'b0;
      word <= 16'h0000;
    end else if (rd_valid) begin
      got  <= 1'b1;
      word <= buffer_read_word;
    end else if (start) begin
      got <= 1'b0;
    end
  end
endmodule

// >>> verif/srb_result_buffer_tb.sv
// Purpose: directed bench for the result circular buffer.
// Assumes: 40 MHz clk_sys; inputs change by non-blocking assignment at edges.
// Notes:   every wait is bounded; a run-out in wt or push counts as a mismatch, in rd it only leaves ok clear.
module srb_result_buffer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import srb_pkg::*;

  logic             clk_sys, resetn, bcfg_wr, upd_wr, continuous_mode;
  logic             self_ctrl_mode, int_pin_sel, res_valid, value_tag, start, use_i2c;
  logic [7:0]       bcfg_wdata, upd_wdata, bcfg_rdata, upd_rdata, result_low_byte;
  logic [3:0]       result_high_nibble;
  logic [LVL_W-1:0] trigger_level, read_index, write_index, trigger_index;
  logic             res_ready, touch_conv_allow, aux_conv_allow, rd_req_spi, rd_req_i2c;
  logic             rd_valid, general_pin_one, general_pin_two, got, ok, conv_set_start;
  logic [15:0]      buffer_read_word, word, w;
  int               n_fail, num_checks, n_start;

  srb_result_buffer u_srb_result_buffer (
    .clk_sys, .resetn, .bcfg_wr, .bcfg_wdata, .bcfg_rdata, .upd_wr, .upd_wdata,
    .upd_rdata, .trigger_level, .continuous_mode, .self_ctrl_mode, .int_pin_sel,
    .res_valid, .res_ready, .result_high_nibble, .result_low_byte, .value_tag,
    .touch_conv_allow, .aux_conv_allow, .conv_set_start, .rd_req_spi, .rd_req_i2c,
    .buffer_read_word, .rd_valid, .general_pin_one, .general_pin_two, .read_index,
    .write_index, .trigger_index
  );

  srb_host_model u_srb_host_model (
    .clk_sys, .resetn, .start, .use_i2c, .got, .word, .rd_req_spi, .rd_req_i2c,
    .buffer_read_word, .rd_valid
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // new conversion sets seen
  always @(posedge clk_sys) begin
    if (conv_set_start === 1'b1) begin
      n_start <= n_start + 1;
    end
  end

  // ------
  // helpers
  // ------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk_sys);
  endtask

  task automatic timeout();
    n_fail++;
    $display("mismatch at %0t: wait ran out", $time);
    summarize();
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic ci(input logic [6:0] r, input logic [6:0] wi, input logic [6:0] t);
    chk(16'(read_index), 16'(r));
    chk(16'(write_index), 16'(wi));
    chk(16'(trigger_index), 16'(t));
  endtask

  // s: 0 write index, 1 read index, 2 full status
  task automatic wt(input int s, input logic [6:0] v);
    for (int k = 0; k < 300; k++) begin
      if (s == 0 ? write_index === v : s == 1 ? read_index === v : bcfg_rdata[1] === v[0]) begin
        return;
      end
      tick();
    end
    timeout();
  endtask

  task automatic wr(input logic u, input logic [7:0] d);
    bcfg_wr <= ~u;
    upd_wr <= u;
    bcfg_wdata <= d;
    upd_wdata <= d;
    tick();
    bcfg_wr <= 1'b0;
    upd_wr <= 1'b0;
    tick();
  endtask

  // value i carries tag i[0] and result i[11:0]
  task automatic push(input int a, input int b);
    for (int i = a; i <= b; i++) begin
      res_valid <= 1'b1;
      result_high_nibble <= i[11:8];
      result_low_byte <= i[7:0];
      value_tag <= i[0];
      for (int k = 0; k <= 300; k++) begin
        if (k == 300) begin
          timeout();
        end
        tick();
        if (res_ready === 1'b1) begin
          break;
        end
      end
    end
    res_valid <= 1'b0;
    tick();
  endtask

  task automatic rd(input logic i2c, output logic [15:0] q, output logic a);
    start <= 1'b1;
    use_i2c <= i2c;
    tick();
    start <= 1'b0;
    a = 1'b0;
    q = 16'h0000;
    for (int k = 0; k < 6 && !a; k++) begin
      tick();
      if (got === 1'b1) begin
        a = 1'b1;
        q = word;
      end
    end
    tick();
    tick();
  endtask

  function automatic logic [15:0] ew(input int v, input logic f, input logic e);
    return {f, e, 1'b0, v[0], v[11:0]};
  endfunction

  // ------
  // sequence
  // ------
  initial begin
    resetn = 1'b0;
    bcfg_wr = 1'b0;
    upd_wr = 1'b0;
    bcfg_wdata = 8'h00;
    upd_wdata = 8'h00;
    trigger_level = 7'h04;
    continuous_mode = 1'b1;
    self_ctrl_mode = 1'b1;
    int_pin_sel = 1'b0;
    res_valid = 1'b0;
    result_high_nibble = 4'h0;
    result_low_byte = 8'h00;
    value_tag = 1'b0;
    start = 1'b0;
    use_i2c = 1'b0;
    n_fail = 0;
    num_checks = 0;
    n_start = 0;
    repeat (6) tick();
    resetn <= 1'b1;
    tick();
    chk(16'(upd_rdata), 16'h0000);
    chk(16'(bcfg_rdata[7]), 16'h0000);
    chk(buffer_read_word, 16'h4000);
    chk({14'h0, touch_conv_allow, aux_conv_allow}, 16'h0003);
    chk({14'h0, general_pin_two, general_pin_one}, 16'h0003);
    ci(7'h01, 7'h01, 7'h01);
    wr(1'b0, 8'h80);
    chk(16'(bcfg_rdata), 16'h0081);
    ci(7'h01, 7'h01, 7'h04);
    chk({14'h0, touch_conv_allow, aux_conv_allow}, 16'h0002);
    push(1, 3);
    wt(0, 7'h04);
    tick();
    chk(16'(general_pin_one), 16'h0001);
    push(4, 4);
    wt(0, 7'h05);
    tick();
    tick();
    chk(16'(general_pin_one), 16'h0000);
    chk(16'(trigger_index), 16'h0008);
    rd(1'b0, w, ok);
    chk(w, ew(1, 1'b0, 1'b0));
    chk(16'(general_pin_one), 16'h0001);
    for (int v = 2; v <= 4; v++) begin
      rd(1'b0, w, ok);
      chk(w, ew(v, 1'b0, v == 4));
    end
    rd(1'b0, w, ok);
    chk({w[14], 15'(read_index)}, 16'h8005);
    chk(16'(n_start), 16'h0002);
    $display("test continuous done");
    wr(1'b1, 8'h80);
    chk(16'(upd_rdata), 16'h0080);
    push(5, 5);
    wt(0, 7'h06);
    rd(1'b0, w, ok);
    chk({15'h0, ok}, 16'h0000);
    rd(1'b1, w, ok);
    chk(w, ew(5, 1'b0, 1'b1));
    wr(1'b1, 8'h60);
    push(6, 6);
    repeat (8) tick();
    chk(16'(write_index), 16'h0006);
    wr(1'b1, 8'h40);
    wt(0, 7'h07);
    wr(1'b1, 8'h00);
    $display("test update control done");
    wr(1'b0, 8'h80);
    push(0, 63);
    wt(2, 7'h01);
    ci(7'h01, 7'h01, 7'h04);
    push(64, 64);
    wt(1, 7'h02);
    chk(16'(write_index), 16'h0002);
    rd(1'b0, w, ok);
    chk(w, ew(1, 1'b1, 1'b0));
    chk(16'(bcfg_rdata), 16'h0080);
    $display("test full done");
    continuous_mode <= 1'b0;
    trigger_level <= 7'h02;
    int_pin_sel <= 1'b1;
    tick();
    wr(1'b0, 8'h80);
    push(1, 4);
    wt(0, 7'h03);
    repeat (4) tick();
    chk({14'h0, general_pin_two, general_pin_one}, 16'h0001);
    chk(16'(write_index), 16'h0003);
    rd(1'b0, w, ok);
    chk(w, ew(1, 1'b0, 1'b0));
    chk(16'(trigger_index), 16'h0004);
    wt(0, 7'h05);
    wr(1'b0, 8'h00);
    tick();
    chk({14'h0, general_pin_two, general_pin_one}, 16'h0003);
    chk(16'(n_start), 16'h0015);
    $display("test single shot done");
    summarize();
  end
endmodule
